//--- rtl/euart_map.svh
// register offsets, field positions, reset values and timing counts
// for the enhanced serial port; included by the design and the bench
`ifndef EUART_MAP_SVH
`define EUART_MAP_SVH

`define EUART_OFS_CTL 8'h00
`define EUART_OFS_DATA 8'h04
`define EUART_OFS_STAT 8'h08
`define EUART_OFS_PWR 8'h0C
`define EUART_OFS_BRGL 8'h10
`define EUART_OFS_BRGH 8'h14

`define EUART_CTL_MODE_HI 7
`define EUART_CTL_MODE_LO 6
`define EUART_CTL_SM2 5
`define EUART_CTL_REN 4
`define EUART_CTL_TX9 3
`define EUART_CTL_RX9 2
`define EUART_CTL_TI 1
`define EUART_CTL_RI 0

`define EUART_STAT_DBUF 7
`define EUART_STAT_BRK 6
`define EUART_STAT_FE 5
`define EUART_STAT_HOLD 4
`define EUART_STAT_BRGSEL 0

`define EUART_PWR_DOUBLE 7
`define EUART_PWR_ERRSEL 6
`define EUART_PWR_BRKRST 0

`define EUART_RST_REG 8'h00
`define EUART_TICKS_LAST 4'hF
`define EUART_TICKS_MID 4'h7
`define EUART_BRK_TICKS 8'hB0

`endif

//--- rtl/euart_pkg.sv
// types shared by the enhanced serial port design
// assumes the map header supplies all numeric constants
package euart_pkg;
  typedef enum logic {TX_IDLE, TX_SHIFT} euart_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} euart_rx_st_t;
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } euart_frame_t;
endpackage : euart_pkg

//--- rtl/euart_top.sv
// enhanced serial port: four modes, baud generator, double buffer
// assumes an apb master on pclk and a timer 1 overflow pulse on pclk
//
// Notes on behaviour
// - mode 0 shifts 8 bits on rxd, clock on txd
// - mode 0 bit is sixteen cpu clocks
// - mode 1 frame: start, 8 data, stop
// - mode 1 stop bit goes to rx_ninth_bit
// - mode 1 rate from timer 1 or generator
// - mode 2 frame adds programmable ninth bit
// - transmitted ninth bit comes from tx_ninth_bit
// - received ninth bit to rx_ninth_bit, stop dropped
// - mode 2 rate is clock/16 or clock/32
// - mode 3 equals mode 2, variable rate
// - generator divides by 16-bit high/low divisor plus one
// - timer 1 overflow halved when baud_double clear
// - generator runs from the cpu clock
// - framing error in status, control bit 7 view
// - eleven low bit times flag a break
// - double buffer gives one stop between characters
// - double buffer off behaves single buffered
// - double buffer raises ti when holding empties
// - tx_ninth_bit latched with byte in holding buffer
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "euart_map.svh"

module euart_top (
  input wire logic pclk, // cpu clock, 200 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic t1_ovf, // timer 1 overflow pulse, same clock
  input wire logic rxd_i, // receive pin level
  output logic rxd_o, // receive pin drive value, mode 0
  output logic rxd_oe, // receive pin drive enable
  output logic txd_o, // transmit pin
  output logic break_rst // one-cycle reset request on break
);
  logic mode_select_hi_q, mode_select_lo_q, sm2_q, ren_q;
  logic tx_ninth_bit_q, rx_ninth_bit_q, ti_q, ri_q;
  logic double_buffer_enable_q, brk_q, fe_q, brgsel_q, brkrst_q;
  logic baud_double_bit_q, error_select_bit_q;
  logic [7:0] brgl_q, brgh_q;
  logic [15:0] brg_cnt_q;
  logic pready_q, pslverr_q, rxd_o_q, rxd_oe_q, txd_q, break_rst_q;
  logic [31:0] prdata_q;
  logic rx_s1_q, rxs_q, half_q, t1half_q;
  euart_pkg::euart_frame_t hold_q, rx_buf_q;
  logic hold_full_q;
  euart_pkg::euart_tx_st_t tx_st_q;
  euart_pkg::euart_rx_st_t rx_st_q;
  logic m0rx_q;
  logic [3:0] tcnt_q, tbit_q, rcnt_q, rbit_q;
  logic [8:0] tsh_q, rsh_q;
  logic [7:0] brk_cnt_q;

  logic [1:0] mode;
  logic nine, db_on, tick, brg_ovf;
  logic acc, wr, rd_phase, hit_ctl, hit_data, hit_stat, hit_pwr;
  logic hit_brgl, hit_brgh, mapped, data_wr, ctl_wr, stat_wr;
  logic tx_idle, tx_bit_end, tx_end, tx_take, nd_go, m0rx_go, m0rx_done;
  logic [3:0] tlast, rlast;
  logic tx_bit, rx_done, rx_keep, brk_hit, ti_set, ri_set;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rxd_o = rxd_o_q;
  assign rxd_oe = rxd_oe_q;
  assign txd_o = txd_q;
  assign break_rst = break_rst_q;

  assign mode = {mode_select_hi_q, mode_select_lo_q};
  assign nine = mode_select_hi_q; // modes 2 and 3 carry a ninth bit
  assign db_on = double_buffer_enable_q & (mode != 2'h0);

  // apb: one wait state, so prdata is settled before pready is seen
  assign rd_phase = psel & penable & ~pready_q;
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign hit_ctl = (paddr == `EUART_OFS_CTL);
  assign hit_data = (paddr == `EUART_OFS_DATA);
  assign hit_stat = (paddr == `EUART_OFS_STAT);
  assign hit_pwr = (paddr == `EUART_OFS_PWR);
  assign hit_brgl = (paddr == `EUART_OFS_BRGL);
  assign hit_brgh = (paddr == `EUART_OFS_BRGH);
  assign mapped = hit_ctl | hit_data | hit_stat | hit_pwr | hit_brgl |
                  hit_brgh;
  assign data_wr = wr & hit_data;
  assign ctl_wr = wr & hit_ctl;
  assign stat_wr = wr & hit_stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= rd_phase;
      pslverr_q <= rd_phase & ~mapped;
      if (rd_phase && !pwrite) begin
        prdata_q <= 32'h0000_0000;
        if (hit_ctl) begin
          prdata_q[7:0] <= {error_select_bit_q ? fe_q : mode_select_hi_q,
                            mode_select_lo_q, sm2_q, ren_q, tx_ninth_bit_q,
                            rx_ninth_bit_q, ti_q, ri_q};
        end else if (hit_data) begin
          prdata_q[7:0] <= rx_buf_q.data;
        end else if (hit_stat) begin
          prdata_q[7:0] <= {double_buffer_enable_q, brk_q, fe_q,
                            hold_full_q, 3'h0, brgsel_q};
        end else if (hit_pwr) begin
          prdata_q[7:0] <= {baud_double_bit_q, error_select_bit_q, 5'h00,
                            brkrst_q};
        end else if (hit_brgl) begin
          prdata_q[7:0] <= brgl_q;
        end else if (hit_brgh) begin
          prdata_q[7:0] <= brgh_q;
        end
      end
    end
  end

  // software-owned control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mode_select_hi_q, mode_select_lo_q, sm2_q, ren_q} <= 4'h0;
      tx_ninth_bit_q <= 1'b0;
      {double_buffer_enable_q, brgsel_q, brkrst_q} <= 3'h0;
      {baud_double_bit_q, error_select_bit_q} <= 2'h0;
      brgl_q <= `EUART_RST_REG;
      brgh_q <= `EUART_RST_REG;
    end else if (wr) begin
      if (hit_ctl) begin
        // with error_select set, bit 7 belongs to the framing flag
        if (!error_select_bit_q) begin
          mode_select_hi_q <= pwdata[`EUART_CTL_MODE_HI];
        end
        mode_select_lo_q <= pwdata[`EUART_CTL_MODE_LO];
        sm2_q <= pwdata[`EUART_CTL_SM2];
        ren_q <= pwdata[`EUART_CTL_REN];
        tx_ninth_bit_q <= pwdata[`EUART_CTL_TX9];
      end else if (hit_stat) begin
        double_buffer_enable_q <= pwdata[`EUART_STAT_DBUF];
        brgsel_q <= pwdata[`EUART_STAT_BRGSEL];
      end else if (hit_pwr) begin
        baud_double_bit_q <= pwdata[`EUART_PWR_DOUBLE];
        error_select_bit_q <= pwdata[`EUART_PWR_ERRSEL];
        brkrst_q <= pwdata[`EUART_PWR_BRKRST];
      end else if (hit_brgl) begin
        brgl_q <= pwdata[7:0];
      end else if (hit_brgh) begin
        brgh_q <= pwdata[7:0];
      end
    end
  end

  // rate: tick is the 16x sample strobe, every bit is sixteen ticks
  assign brg_ovf = (brg_cnt_q == 16'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_cnt_q <= 16'h0000;
    end else if (brg_ovf) begin
      brg_cnt_q <= {brgh_q, brgl_q};
    end else begin
      brg_cnt_q <= brg_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
      t1half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
      if (t1_ovf) begin
        t1half_q <= ~t1half_q;
      end
    end
  end

  always_comb begin
    case (mode)
      2'h0: tick = 1'b1;
      2'h2: tick = baud_double_bit_q | half_q;
      default: begin
        if (brgsel_q) begin
          tick = brg_ovf;
        end else begin
          tick = t1_ovf & (baud_double_bit_q | t1half_q);
        end
      end
    endcase
  end

  // pin synchroniser; only rxs_q is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rxs_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd_i;
      rxs_q <= rx_s1_q;
    end
  end

  // transmit engine, also runs mode 0 receive since the pins are shared
  assign tlast = (mode == 2'h0) ? 4'h7 : (nine ? 4'hA : 4'h9);
  assign tx_idle = (tx_st_q == euart_pkg::TX_IDLE);
  assign tx_bit_end = !tx_idle && tick && tcnt_q == `EUART_TICKS_LAST;
  assign tx_end = tx_bit_end && tbit_q == tlast;
  assign tx_take = db_on & hold_full_q & (tx_idle | tx_end);
  assign nd_go = data_wr & ~db_on & tx_idle;
  assign m0rx_go = (mode == 2'h0) & ren_q & ~ri_q & tx_idle & ~data_wr;
  assign m0rx_done = tx_end & m0rx_q;

  always_comb begin
    if (tbit_q == 4'h0) begin
      tx_bit = 1'b0; // start bit
    end else if (tbit_q <= 4'h8) begin
      tx_bit = tsh_q[0];
    end else if (tbit_q == 4'h9 && nine) begin
      tx_bit = db_on ? tsh_q[8] : tx_ninth_bit_q;
    end else begin
      tx_bit = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= euart_pkg::TX_IDLE;
      m0rx_q <= 1'b0;
      tcnt_q <= 4'h0;
      tbit_q <= 4'h0;
      tsh_q <= 9'h000;
    end else if (tx_take) begin
      tx_st_q <= euart_pkg::TX_SHIFT;
      m0rx_q <= 1'b0;
      tcnt_q <= 4'h0;
      tbit_q <= 4'h0;
      tsh_q <= hold_q; // byte and its ninth bit together
    end else if (nd_go || m0rx_go) begin
      tx_st_q <= euart_pkg::TX_SHIFT;
      m0rx_q <= m0rx_go;
      tcnt_q <= 4'h0;
      tbit_q <= (mode == 2'h0) ? 4'h0 : 4'h0;
      tsh_q <= {1'b0, pwdata[7:0]};
    end else if (!tx_idle && tick) begin
      tcnt_q <= tcnt_q + 4'h1;
      if (tcnt_q == `EUART_TICKS_LAST) begin
        tbit_q <= tbit_q + 4'h1;
        if (mode == 2'h0) begin
          // lsb first both ways; receive samples at the end of the clock high half
          tsh_q[7:0] <= m0rx_q ? {rxs_q, tsh_q[7:1]} : {1'b0, tsh_q[7:1]};
        end else if (tbit_q != 4'h0 && tbit_q <= 4'h8) begin
          tsh_q[7:0] <= {1'b0, tsh_q[7:1]};
        end
        if (tbit_q == tlast) begin
          tx_st_q <= euart_pkg::TX_IDLE;
        end
      end
    end
  end

  // pins: mode 0 drives the shift clock on txd, and data on rxd only when transmitting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q <= 1'b1;
      rxd_o_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else if (tx_idle) begin
      txd_q <= 1'b1;
      rxd_o_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end else if (mode == 2'h0) begin
      txd_q <= tcnt_q[3]; // low half then high half
      rxd_o_q <= tsh_q[0];
      rxd_oe_q <= ~m0rx_q;
    end else begin
      txd_q <= tx_bit;
      rxd_o_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end
  end

  // holding buffer; a write while it is full is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_full_q <= 1'b0;
      hold_q <= '0;
    end else if (data_wr && db_on && !hold_full_q) begin
      hold_full_q <= 1'b1;
      hold_q <= {tx_ninth_bit_q, pwdata[7:0]};
    end else if (tx_take) begin
      hold_full_q <= 1'b0;
    end
  end

  // asynchronous receiver, modes 1 to 3
  assign rlast = nine ? 4'h9 : 4'h8;
  assign rx_done = rx_st_q == euart_pkg::RX_DATA && tick &&
                   rcnt_q == `EUART_TICKS_LAST && rbit_q == rlast;
  assign rx_keep = rx_done & ~ri_q; // unread data is never overwritten

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= euart_pkg::RX_IDLE;
      rcnt_q <= 4'h0;
      rbit_q <= 4'h0;
      rsh_q <= 9'h000;
    end else if (mode == 2'h0 || !ren_q) begin
      rx_st_q <= euart_pkg::RX_IDLE;
    end else if (tick) begin
      case (rx_st_q)
        euart_pkg::RX_IDLE: begin
          rcnt_q <= 4'h0;
          if (!rxs_q) begin
            rx_st_q <= euart_pkg::RX_START;
          end
        end
        euart_pkg::RX_START: begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == `EUART_TICKS_MID) begin
            // a glitch shorter than half a bit is not a start
            rx_st_q <= rxs_q ? euart_pkg::RX_IDLE : euart_pkg::RX_DATA;
            rcnt_q <= 4'h0;
            rbit_q <= 4'h0;
          end
        end
        euart_pkg::RX_DATA: begin
          rcnt_q <= rcnt_q + 4'h1;
          if (rcnt_q == `EUART_TICKS_LAST) begin
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q < 4'h8) begin
              rsh_q[7:0] <= {rxs_q, rsh_q[7:1]};
            end else if (rbit_q == 4'h8 && nine) begin
              rsh_q[8] <= rxs_q;
            end
            if (rbit_q == rlast) begin
              rx_st_q <= euart_pkg::RX_IDLE;
            end
          end
        end
        default: rx_st_q <= euart_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= '0;
      rx_ninth_bit_q <= 1'b0;
    end else if (rx_keep) begin
      rx_buf_q <= {1'b0, rsh_q[7:0]};
      rx_ninth_bit_q <= nine ? rsh_q[8] : rxs_q;
    end else if (m0rx_done && !ri_q) begin
      rx_buf_q <= {1'b0, rxs_q, tsh_q[7:1]};
    end else if (ctl_wr) begin
      rx_ninth_bit_q <= pwdata[`EUART_CTL_RX9];
    end
  end

  // break: 11 bit times of low samples, in ticks
  assign brk_hit = (mode != 2'h0) && tick && !rxs_q &&
                   brk_cnt_q == `EUART_BRK_TICKS - 8'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_cnt_q <= 8'h00;
      break_rst_q <= 1'b0;
    end else begin
      break_rst_q <= brk_hit & brkrst_q;
      if (rxs_q || mode == 2'h0) begin
        brk_cnt_q <= 8'h00;
      end else if (tick && brk_cnt_q != `EUART_BRK_TICKS) begin
        brk_cnt_q <= brk_cnt_q + 8'h01;
      end
    end
  end

  // sticky flags: a hardware set wins over a software clear
  assign ti_set = db_on ? tx_take
                        : (tx_end & ~m0rx_q);
  assign ri_set = rx_keep | m0rx_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ti_q, ri_q, fe_q, brk_q} <= 4'h0;
    end else begin
      ti_q <= ti_set | (ti_q & ~(ctl_wr & ~pwdata[`EUART_CTL_TI]));
      ri_q <= ri_set | (ri_q & ~(ctl_wr & ~pwdata[`EUART_CTL_RI]));
      fe_q <= (rx_done & ~rxs_q) | (fe_q &
              ~(stat_wr & ~pwdata[`EUART_STAT_FE]) &
              ~(ctl_wr & error_select_bit_q &
                ~pwdata[`EUART_CTL_MODE_HI]));
      brk_q <= brk_hit | (brk_q &
               ~(stat_wr & ~pwdata[`EUART_STAT_BRK]));
    end
  end

  a_m0_rate: assert property (@(posedge pclk) disable iff (!presetn)
    mode == 2'h0 |-> tick) else $error("mode 0 tick missing");
  a_m2_half: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == 2'h2 && !baud_double_bit_q && tick) |=> (!tick ||
    mode != 2'h2 || baud_double_bit_q))
    else $error("mode 2 divide by 32 broken");
  a_brg_src: assert property (@(posedge pclk) disable iff (!presetn)
    (mode[0] && brgsel_q) |-> (tick == (brg_cnt_q == 16'h0000)))
    else $error("generator rate not used");
  a_stop_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_keep && mode == 2'h1) |=> rx_ninth_bit_q == $past(rxs_q))
    else $error("stop bit not kept in rb8");
  a_fe_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done && !rxs_q) |=> fe_q) else $error("framing error missed");
  a_brk_flag: assert property (@(posedge pclk) disable iff (!presetn)
    brk_hit |=> brk_q ##0 (break_rst_q == $past(brkrst_q)))
    else $error("break not flagged");
  a_db_ti: assert property (@(posedge pclk) disable iff (!presetn)
    tx_take |=> ti_q && tbit_q == 4'h0 && !tx_idle)
    else $error("holding empty without ti");
  a_start_low: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_idle && mode != 2'h0 && tbit_q == 4'h0 && tcnt_q == 4'h1)
    |=> !txd_q) else $error("start bit not low");
  a_ninth_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (data_wr && db_on && !hold_full_q) |=> hold_full_q &&
    hold_q.ninth == $past(tx_ninth_bit_q)) else $error("ninth bit lost");
  a_m0_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_idle && mode == 2'h0 && !m0rx_q) |=> rxd_oe_q)
    else $error("mode 0 data pin not driven");
endmodule : euart_top

//--- tb/euart_peer.sv
// remote asynchronous serial node facing the serial port pins
// assumes bit lengths in pclk cycles are handed in by the caller;
// the receive line has no pull-up, so the model drives it high when idle
`timescale 1ns/10ps

module euart_peer (
  input wire logic clk, // same clock as the port, used as time base
  input wire logic txd, // port transmit pin
  output logic rxd // drive onto the port receive pin
);
  initial rxd = 1'b1;

  // frame bits land lsb first: f[0] is the start bit
  task automatic recv(input int nb, input int bl, output logic [10:0] f,
                      output int gap);
    f = '0;
    gap = 0;
    while (txd !== 1'b0) begin
      @(posedge clk);
      gap++;
    end
    repeat (bl / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd;
      if (i < nb - 1) begin
        repeat (bl) @(posedge clk);
      end
    end
    // stay past the stop bit so the sender's flag has settled
    repeat (bl / 2 + 2) @(posedge clk);
  endtask : recv

  // one idle bit after the frame lets the receiver finish its stop bit
  task automatic send(input int nb, input int bl, input logic [10:0] f);
    for (int i = 0; i < nb; i++) begin
      rxd <= f[i];
      repeat (bl) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bl) @(posedge clk);
  endtask : send
endmodule : euart_peer

//--- tb/enhanced_uart_with_baud_generator_tb.sv
// self-checking bench for the enhanced serial port over apb
// assumes the peer model on the pins and a free timer 1 overflow pulse
`timescale 1ns/10ps
`include "euart_map.svh"

module enhanced_uart_with_baud_generator_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic t1_ovf = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd_o;
  logic rxd_oe;
  logic txd_o;
  logic break_rst;
  logic peer_rxd;
  logic rxd_line;
  logic [31:0] rd;
  logic err;
  logic [10:0] f1;
  logic [10:0] f2;
  int g1;
  int g2;
  int brk_cnt = 0;
  logic [7:0] m0b;
  int m0p;
  logic m0oe;
  int failures = 0;
  int num_checks = 0;

  assign rxd_line = rxd_oe ? rxd_o : peer_rxd;

  always #2.5 pclk = ~pclk;
  // overflow every second clock: a steady, known timer rate
  always @(posedge pclk) t1_ovf <= ~t1_ovf;
  always @(posedge pclk) if (break_rst === 1'b1) brk_cnt <= brk_cnt + 1;

  euart_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t1_ovf(t1_ovf),
    .rxd_i(rxd_line), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o),
    .break_rst(break_rst)
  );

  euart_peer peer (.clk(pclk), .txd(txd_o), .rxd(peer_rxd));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // idle edge first, so a release and the next setup never share a step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, {24'h000000, e});
  endtask : rdc

  // mode 0 far side: take rxd one clock after each shift clock rise
  task automatic m0_cap(output logic [7:0] b, output int p,
                        output logic oe);
    time t0;
    b = 8'h00;
    p = 0;
    oe = 1'b0;
    t0 = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_o);
      @(posedge pclk);
      b[i] = rxd_o;
      if (i == 0) begin
        t0 = $time;
        oe = rxd_oe;
      end else if (i == 1) begin
        p = int'(($time - t0) / 64'h0000_0000_0000_0005);
      end
    end
  endtask : m0_cap

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`EUART_OFS_STAT, 8'h00, "stat_reset");
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    // mode 2 at clock/16, single buffer, ninth bit one
    wr(`EUART_OFS_PWR, 8'h80);
    wr(`EUART_OFS_CTL, 8'h88);
    fork
      peer.recv(11, 16, f1, g1);
      wr(`EUART_OFS_DATA, 8'hA5);
    join
    chk("m2_frame", {21'h0, f1},
        {21'h0, 1'b1, 1'b1, 8'hA5, 1'b0});
    rdc(`EUART_OFS_CTL, 8'h8A, "m2_ti");
    // mode 3, generator divisor 1, double buffer, ninth bit per byte
    wr(`EUART_OFS_STAT, 8'h81);
    wr(`EUART_OFS_BRGL, 8'h01);
    wr(`EUART_OFS_BRGH, 8'h00);
    wr(`EUART_OFS_CTL, 8'hC8);
    fork
      begin
        peer.recv(11, 32, f1, g1);
        peer.recv(11, 32, f2, g2);
      end
      begin
        wr(`EUART_OFS_DATA, 8'h11);
        rdc(`EUART_OFS_CTL, 8'hCA, "db_ti");
        wr(`EUART_OFS_CTL, 8'hC0);
        wr(`EUART_OFS_DATA, 8'h22);
      end
    join
    chk("db_frame1", {21'h0, f1},
        {21'h0, 1'b1, 1'b1, 8'h11, 1'b0});
    chk("db_frame2", {21'h0, f2},
        {21'h0, 1'b1, 1'b0, 8'h22, 1'b0});
    chk("db_gap", 32'(g2), 32'h0000_0000);
    // mode 3 receive: ninth bit zero, stop one
    wr(`EUART_OFS_STAT, 8'h01);
    wr(`EUART_OFS_CTL, 8'hD0);
    peer.send(11, 32, {1'b1, 1'b0, 8'h3C, 1'b0});
    rdc(`EUART_OFS_CTL, 8'hD1, "m3_rx_ctl");
    rdc(`EUART_OFS_DATA, 8'h3C, "m3_rx_data");
    // mode 1 from timer 1 halved: 64 clocks a bit
    wr(`EUART_OFS_STAT, 8'h00);
    wr(`EUART_OFS_PWR, 8'h00);
    wr(`EUART_OFS_CTL, 8'h50);
    peer.send(10, 64, {1'b0, 1'b1, 8'h96, 1'b0});
    rdc(`EUART_OFS_CTL, 8'h55, "m1_rx_ctl");
    rdc(`EUART_OFS_DATA, 8'h96, "m1_rx_data");
    wr(`EUART_OFS_CTL, 8'h50);
    peer.send(10, 64, {1'b0, 1'b0, 8'h5A, 1'b0});
    rdc(`EUART_OFS_STAT, 8'h20, "fe_flag");
    wr(`EUART_OFS_PWR, 8'h40);
    rdc(`EUART_OFS_CTL, 8'hD1, "fe_view");
    // long low run with break reset enabled
    wr(`EUART_OFS_PWR, 8'h01);
    peer.send(11, 80, 11'h000);
    apb(1'b0, `EUART_OFS_STAT, 32'h0000_0000);
    chk("brk_flag", {31'h0, rd[6]}, 32'h0000_0001);
    chk("brk_rst_cnt", 32'(brk_cnt), 32'h0000_0001);
    // mode 0 transmit: shift clock on txd, data on rxd
    wr(`EUART_OFS_STAT, 8'h00);
    wr(`EUART_OFS_CTL, 8'h00);
    fork
      wr(`EUART_OFS_DATA, 8'h6C);
      m0_cap(m0b, m0p, m0oe);
    join
    chk("m0_data", {24'h000000, m0b}, 32'h0000_006C);
    chk("m0_drive", {31'h0, m0oe}, 32'h0000_0001);
    chk("m0_period", 32'(m0p), 32'h0000_0010);
    repeat (16) @(posedge pclk);
    rdc(`EUART_OFS_CTL, 8'h02, "m0_ti");
    summarize();
  end
endmodule : enhanced_uart_with_baud_generator_tb
